// file: design/llsm_monitor.sv
// Lock-lost status monitor and device status flags with register port and pins.
// Assumes a byte-wide register port synchronous to i_clk; the loop supplies its
// frequency error as a magnitude code where code k means at least the k-th threshold.
// Contract
// - Live lock-lost bit is 1 when the loop is unlocked, 0 when locked.
// - Active-low lock-lost pin follows the monitor state.
// - Separate set and clear frequency comparisons give hysteresis.
// - With timer on, clearing waits an extra programmed delay.
// - Timer enable bit 1 enables clear timer, 0 bypasses it.
// - Clear delay is 35 bits over five bytes, top byte three bits.
// - Lock-lost sticky flag sets on fault and holds until cleared.
// - Writing 0 clears a flag only when its live cause is gone.
// - Mask bit 0 lets lock-lost drive the interrupt; 1 ignores it.
// - Four-bit set and clear threshold fields select ppm limits.
// - Device calibration indicator reads 1 during calibration.
// - Crystal loss indicator reads 1 when crystal signal insufficient.
// - Crystal lock error reads 1 when crystal input not locked.
// - Bus timeout indicator reads 1 once a timeout occurred.
// - Loop calibration indicator reads 1 while the loop calibrates.
// - Device sticky flags at bits 0,2,3,5 behave like lock-lost flag.
// - Interrupt releases only after all unmasked causing flags cleared.
`timescale 1ns/1ps
module llsm_monitor
    import llsm_pkg::*;
#(
    parameter int WAIT_W = LLSM_WAIT_W
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    // Register port
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    output logic            o_reg_rvalid,
    // Loop frequency error code, 0 = below 0.1 ppm, 10 = at least 10000 ppm
    input  wire logic [3:0] i_freq_err_code,
    // Raw status causes
    input  wire logic       i_device_tuning,
    input  wire logic       i_crystal_signal_missing,
    input  wire logic       i_crystal_unlocked,
    input  wire logic       i_bus_timeout,
    input  wire logic       i_loop_tuning,
    // Pins
    output logic            o_lock_lost_pin_n,
    output logic            o_irq_pin_n
);
    // Clear-threshold code k maps to the same ppm as error code k; set code k to k+2
    localparam logic [3:0] SET_OFFSET = 4'h2;

    // Lock-lost state and clear delay counter
    logic              lock_lost_live_q;
    logic              wait_busy_q;
    logic [WAIT_W-1:0] wait_cnt_q;

    // Registered live indicators
    logic [7:0]        dev_live_q;
    logic              loop_tuning_live_q;

    // Configuration
    logic [7:0]        dev_mask_q;
    logic              lock_lost_irq_block_q;
    logic              loop_mask_q;
    logic [3:0]        lock_lost_assert_limit_q;
    logic [3:0]        lock_regain_limit_q;
    logic              lock_regain_timer_on_q;
    logic [WAIT_W-1:0] lock_regain_wait_count_q;

    // Sticky flags
    logic [7:0]        dev_sticky;
    logic              lock_lost_sticky;
    logic              loop_tuning_sticky;

    // Threshold comparisons
    logic              set_hit;
    logic              clr_hit;
    logic [4:0]        set_level;

    // Clear strobes
    logic              wr_dev_sticky;
    logic              wr_lock_sticky;
    logic              wr_loop_sticky;

    // Interrupt terms
    logic              dev_irq;
    logic              lock_irq;
    logic              loop_irq;
    logic              irq_any;

    // Set and clear comparisons against their own thresholds
    // The set limit sits two codes higher than the clear limit of the same index,
    // so equal field values still leave a gap between the two comparisons
    assign set_level = {1'b0, lock_lost_assert_limit_q} + {1'b0, SET_OFFSET};
    assign set_hit   = {1'b0, i_freq_err_code} >= set_level;
    assign clr_hit   = i_freq_err_code <= lock_regain_limit_q;

    // Lock-lost state with optional regain delay. A set always wins and drops a running
    // delay; losing the clear condition mid-delay drops it too, so the loop must stay
    // inside the clear limit for the whole programmed wait before lock is reported
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lock_lost_live_q <= 1'b1;
            wait_busy_q      <= 1'b0;
            wait_cnt_q       <= '0;
        end else if (set_hit) begin
            lock_lost_live_q <= 1'b1;
            wait_busy_q      <= 1'b0;
        end else if (lock_lost_live_q && clr_hit) begin
            if (!lock_regain_timer_on_q) begin
                lock_lost_live_q <= 1'b0;
            end else if (!wait_busy_q) begin
                wait_busy_q <= 1'b1;
                wait_cnt_q  <= lock_regain_wait_count_q;
                if (lock_regain_wait_count_q == '0) begin
                    lock_lost_live_q <= 1'b0;
                    wait_busy_q      <= 1'b0;
                end
            end else if (wait_cnt_q <= WAIT_W'(1)) begin
                lock_lost_live_q <= 1'b0;
                wait_busy_q      <= 1'b0;
            end else begin
                wait_cnt_q <= wait_cnt_q - WAIT_W'(1);
            end
        end else begin
            wait_busy_q <= 1'b0;                                                 // Restart delay if clear lost
        end
    end

    // Live device and loop indicators, registered
    // Bits with no status source stay zero
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dev_live_q         <= 8'h00;
            loop_tuning_live_q <= 1'b0;
        end else begin
            dev_live_q                       <= 8'h00;
            dev_live_q[LLSM_BIT_DEV_TUNE]    <= i_device_tuning;
            dev_live_q[LLSM_BIT_XTAL_MISS]   <= i_crystal_signal_missing;
            dev_live_q[LLSM_BIT_XTAL_UNLOCK] <= i_crystal_unlocked;
            dev_live_q[LLSM_BIT_BUS_TMO]     <= i_bus_timeout;
            loop_tuning_live_q               <= i_loop_tuning;
        end
    end

    // Write strobes that clear flags by writing zero
    // Writing one to a flag bit leaves it alone
    assign wr_dev_sticky  = i_reg_wr && (i_reg_addr == LLSM_OFS_DEV_STICKY);
    assign wr_lock_sticky = i_reg_wr && (i_reg_addr == LLSM_OFS_LOCK_STICKY)
                            && !i_reg_wdata[LLSM_BIT_LOCK_LOST];
    assign wr_loop_sticky = i_reg_wr && (i_reg_addr == LLSM_OFS_LOOP_STICKY)
                            && !i_reg_wdata[LLSM_BIT_LOOP_TUNE];

    // Device sticky flags, one per used status bit
    // Unused bit positions read as zero and never raise the interrupt
    for (genvar g = 0; g < 8; g++) begin : g_dev
        if (LLSM_DEV_FIELDS[g]) begin : g_used
            llsm_sticky u_flag (
                .i_clk     (i_clk),
                .i_reset_n (i_reset_n),
                .i_live    (dev_live_q[g]),
                .i_clear   (wr_dev_sticky && !i_reg_wdata[g]),
                .o_flag    (dev_sticky[g])
            );
        end else begin : g_none
            assign dev_sticky[g] = 1'b0;
        end
    end

    // Lock-lost sticky flag
    llsm_sticky u_lock_flag (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_live    (lock_lost_live_q),
        .i_clear   (wr_lock_sticky),
        .o_flag    (lock_lost_sticky)
    );

    // Loop calibration sticky flag
    llsm_sticky u_loop_flag (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_live    (loop_tuning_live_q),
        .i_clear   (wr_loop_sticky),
        .o_flag    (loop_tuning_sticky)
    );

    // Interrupt masks; zero lets the matching flag reach the interrupt pin
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dev_mask_q            <= LLSM_RST_MASK;
            lock_lost_irq_block_q <= LLSM_RST_MASK[LLSM_BIT_LOCK_LOST];
            loop_mask_q           <= LLSM_RST_MASK[LLSM_BIT_LOOP_TUNE];
        end else if (i_reg_wr) begin
            if (i_reg_addr == LLSM_OFS_DEV_MASK) begin
                dev_mask_q <= i_reg_wdata & LLSM_DEV_FIELDS;
            end
            if (i_reg_addr == LLSM_OFS_LOCK_MASK) begin
                lock_lost_irq_block_q <= i_reg_wdata[LLSM_BIT_LOCK_LOST];
            end
            if (i_reg_addr == LLSM_OFS_LOOP_MASK) begin
                loop_mask_q <= i_reg_wdata[LLSM_BIT_LOOP_TUNE];
            end
        end
    end

    // Threshold codes and clear timer enable
    // A new limit takes effect at the next comparison; no state is flushed
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lock_lost_assert_limit_q <= LLSM_RST_ASSERT;
            lock_regain_limit_q      <= LLSM_RST_REGAIN;
            lock_regain_timer_on_q   <= LLSM_RST_TIMER;
        end else if (i_reg_wr) begin
            unique case (i_reg_addr)
                LLSM_OFS_ASSERT_LIM: begin
                    lock_lost_assert_limit_q <= i_reg_wdata[LLSM_LIM_LSB +: 4];
                end
                LLSM_OFS_REGAIN_LIM: begin
                    lock_regain_limit_q <= i_reg_wdata[LLSM_LIM_LSB +: 4];
                end
                LLSM_OFS_TIMER_ON: begin
                    lock_regain_timer_on_q <= i_reg_wdata[LLSM_BIT_TIMER_ON];
                end
                default: begin
                end
            endcase
        end
    end

    // Clear delay, written a byte at a time, least significant byte first
    // A running delay keeps the value it loaded; new bytes apply to the next wait
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lock_regain_wait_count_q <= WAIT_W'(LLSM_RST_WAIT);
        end else if (i_reg_wr) begin
            unique case (i_reg_addr)
                LLSM_OFS_WAIT_B0: begin
                    lock_regain_wait_count_q[7:0] <= i_reg_wdata;
                end
                LLSM_OFS_WAIT_B0 + 16'h1: begin
                    lock_regain_wait_count_q[15:8] <= i_reg_wdata;
                end
                LLSM_OFS_WAIT_B0 + 16'h2: begin
                    lock_regain_wait_count_q[23:16] <= i_reg_wdata;
                end
                LLSM_OFS_WAIT_B0 + 16'h3: begin
                    lock_regain_wait_count_q[31:24] <= i_reg_wdata;
                end
                LLSM_OFS_WAIT_B4: begin
                    lock_regain_wait_count_q[34:32] <= i_reg_wdata[LLSM_WAIT_TOP_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read port, one cycle latency; unmapped addresses read zero
    // A read of a sticky byte sees the flags before any clear written in the same cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= 8'h00;
                unique case (i_reg_addr)
                    LLSM_OFS_DEV_LIVE: begin
                        o_reg_rdata <= dev_live_q;
                    end
                    LLSM_OFS_LOCK_LIVE: begin
                        o_reg_rdata[LLSM_BIT_LOCK_LOST] <= lock_lost_live_q;
                    end
                    LLSM_OFS_LOOP_LIVE: begin
                        o_reg_rdata[LLSM_BIT_LOOP_TUNE] <= loop_tuning_live_q;
                    end
                    LLSM_OFS_DEV_STICKY: begin
                        o_reg_rdata <= dev_sticky;
                    end
                    LLSM_OFS_LOCK_STICKY: begin
                        o_reg_rdata[LLSM_BIT_LOCK_LOST] <= lock_lost_sticky;
                    end
                    LLSM_OFS_LOOP_STICKY: begin
                        o_reg_rdata[LLSM_BIT_LOOP_TUNE] <= loop_tuning_sticky;
                    end
                    LLSM_OFS_DEV_MASK: begin
                        o_reg_rdata <= dev_mask_q;
                    end
                    LLSM_OFS_LOCK_MASK: begin
                        o_reg_rdata[LLSM_BIT_LOCK_LOST] <= lock_lost_irq_block_q;
                    end
                    LLSM_OFS_LOOP_MASK: begin
                        o_reg_rdata[LLSM_BIT_LOOP_TUNE] <= loop_mask_q;
                    end
                    LLSM_OFS_ASSERT_LIM: begin
                        o_reg_rdata[LLSM_LIM_LSB +: 4] <= lock_lost_assert_limit_q;
                    end
                    LLSM_OFS_REGAIN_LIM: begin
                        o_reg_rdata[LLSM_LIM_LSB +: 4] <= lock_regain_limit_q;
                    end
                    LLSM_OFS_TIMER_ON: begin
                        o_reg_rdata[LLSM_BIT_TIMER_ON] <= lock_regain_timer_on_q;
                    end
                    LLSM_OFS_WAIT_B0: begin
                        o_reg_rdata <= lock_regain_wait_count_q[7:0];
                    end
                    LLSM_OFS_WAIT_B0 + 16'h1: begin
                        o_reg_rdata <= lock_regain_wait_count_q[15:8];
                    end
                    LLSM_OFS_WAIT_B0 + 16'h2: begin
                        o_reg_rdata <= lock_regain_wait_count_q[23:16];
                    end
                    LLSM_OFS_WAIT_B0 + 16'h3: begin
                        o_reg_rdata <= lock_regain_wait_count_q[31:24];
                    end
                    LLSM_OFS_WAIT_B4: begin
                        o_reg_rdata[LLSM_WAIT_TOP_W-1:0] <= lock_regain_wait_count_q[34:32];
                    end
                    default: begin
                        o_reg_rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

    // Interrupt from any unmasked sticky flag; it holds until every such flag is clear
    assign dev_irq  = |(dev_sticky & ~dev_mask_q);
    assign lock_irq = lock_lost_sticky & ~lock_lost_irq_block_q;
    assign loop_irq = loop_tuning_sticky & ~loop_mask_q;
    assign irq_any  = dev_irq | lock_irq | loop_irq;

    // Output pins, registered
    // The interrupt pin lags its flags by one cycle, the lock pin lags the live bit by one
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_lock_lost_pin_n <= 1'b0;
            o_irq_pin_n       <= 1'b1;
        end else begin
            o_lock_lost_pin_n <= ~lock_lost_live_q;
            o_irq_pin_n       <= ~irq_any;
        end
    end
endmodule // llsm_monitor

// file: design/llsm_pkg.sv
// Package for the lock-lost status monitor: register offsets, field positions, reset values.
// Assumes an 8-bit register port with 16-bit byte addresses.
package llsm_pkg;
    // Register byte offsets
    localparam logic [15:0] LLSM_OFS_DEV_LIVE    = 16'h000c;
    localparam logic [15:0] LLSM_OFS_LOCK_LIVE   = 16'h000e;
    localparam logic [15:0] LLSM_OFS_LOOP_LIVE   = 16'h000f;
    localparam logic [15:0] LLSM_OFS_DEV_STICKY  = 16'h0011;
    localparam logic [15:0] LLSM_OFS_LOCK_STICKY = 16'h0013;
    localparam logic [15:0] LLSM_OFS_LOCK_MASK   = 16'h0019;
    localparam logic [15:0] LLSM_OFS_DEV_MASK    = 16'h0017;
    localparam logic [15:0] LLSM_OFS_LOOP_STICKY = 16'h0014;
    localparam logic [15:0] LLSM_OFS_LOOP_MASK   = 16'h001a;
    localparam logic [15:0] LLSM_OFS_ASSERT_LIM  = 16'h009e;
    localparam logic [15:0] LLSM_OFS_REGAIN_LIM  = 16'h00a0;
    localparam logic [15:0] LLSM_OFS_TIMER_ON    = 16'h00a2;
    localparam logic [15:0] LLSM_OFS_WAIT_B0     = 16'h00a8;
    localparam logic [15:0] LLSM_OFS_WAIT_B4     = 16'h00ac;
    // Field positions
    localparam int LLSM_BIT_DEV_TUNE    = 0;
    localparam int LLSM_BIT_XTAL_MISS   = 2;
    localparam int LLSM_BIT_XTAL_UNLOCK = 3;
    localparam int LLSM_BIT_BUS_TMO     = 5;
    localparam int LLSM_BIT_LOCK_LOST   = 1;
    localparam int LLSM_BIT_LOOP_TUNE   = 5;
    localparam int LLSM_BIT_TIMER_ON    = 1;
    localparam int LLSM_LIM_LSB         = 4;
    localparam int LLSM_WAIT_W          = 35;
    localparam int LLSM_WAIT_TOP_W      = 3;
    // Used bits of the device status byte
    localparam logic [7:0] LLSM_DEV_FIELDS = 8'h2d;
    // Reset values
    localparam logic [7:0]             LLSM_RST_MASK   = 8'h00;
    localparam logic [3:0]             LLSM_RST_ASSERT = 4'h2;  // 10 ppm
    localparam logic [3:0]             LLSM_RST_REGAIN = 4'h0;  // 0.1 ppm
    localparam logic                   LLSM_RST_TIMER  = 1'b0;
    localparam logic [LLSM_WAIT_W-1:0] LLSM_RST_WAIT   = 35'h0;
endpackage

// file: design/llsm_sticky.sv
// Sticky flag with clear-by-zero write, refused while its live cause stands.
// Assumes the write strobe and data are synchronous to i_clk.
`timescale 1ns/1ps
module llsm_sticky (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_live,
    input  wire logic i_clear,
    output logic      o_flag
);
    // Set wins over clear; clear accepted only with the live cause gone
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_flag <= 1'b0;
        end else if (i_live) begin
            o_flag <= 1'b1;
        end else if (i_clear) begin
            o_flag <= 1'b0;
        end
    end
endmodule // llsm_sticky

// file: dv/llsm_monitor_asserts.sv
// Port checker for the lock-lost status monitor.
// Assumes it is bound to llsm_monitor and sees only its ports.
`timescale 1ns/1ps
module llsm_monitor_asserts
    import llsm_pkg::*;
#(
    parameter int WAIT_W = LLSM_WAIT_W
) (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [15:0] i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        o_reg_rvalid,
    input wire logic [3:0]  i_freq_err_code,
    input wire logic        o_lock_lost_pin_n,
    input wire logic        o_irq_pin_n
);
    logic lock_mask_q;
    logic timer_on_q;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // Shadow of the lock-lost mask and clear timer enable
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lock_mask_q <= 1'b0;
            timer_on_q  <= 1'b0;
        end else if (i_reg_wr) begin
            if (i_reg_addr == LLSM_OFS_LOCK_MASK)
                lock_mask_q <= i_reg_wdata[LLSM_BIT_LOCK_LOST];
            if (i_reg_addr == LLSM_OFS_TIMER_ON)
                timer_on_q <= i_reg_wdata[LLSM_BIT_TIMER_ON];
        end
    end

    // Register port answers each read once
    read_answered_a: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    read_quiet_a: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("read valid without read");
    // Lock monitor thresholds and pin
    lock_set_a: assert property (i_freq_err_code == 4'ha |-> ##2 !o_lock_lost_pin_n)
        else $error("lock-lost not set");
    lock_clear_a: assert property (i_freq_err_code == 4'h0 && !timer_on_q |-> ##2 o_lock_lost_pin_n)
        else $error("lock-lost not cleared");
    live_pin_match_a: assert property (i_reg_rd && i_reg_addr == LLSM_OFS_LOCK_LIVE
        |=> o_reg_rdata[LLSM_BIT_LOCK_LOST] == !o_lock_lost_pin_n) else $error("pin and live bit differ");
    sticky_holds_a: assert property (!o_lock_lost_pin_n && i_reg_rd && i_reg_addr == LLSM_OFS_LOCK_STICKY
        |=> o_reg_rdata[LLSM_BIT_LOCK_LOST]) else $error("sticky flag not set");
    // Interrupt pin
    irq_raise_a: assert property ($fell(o_lock_lost_pin_n) && !lock_mask_q |=> !o_irq_pin_n)
        else $error("interrupt not raised");
    irq_release_a: assert property ($rose(o_irq_pin_n) |-> $past(i_reg_wr) || $past(i_reg_wr, 2))
        else $error("interrupt released without write");

    cover property ($rose(o_lock_lost_pin_n));
    cover property ($rose(o_irq_pin_n));
    cover property (timer_on_q && $rose(o_lock_lost_pin_n));
endmodule // llsm_monitor_asserts

bind llsm_monitor llsm_monitor_asserts #(.WAIT_W(WAIT_W)) u_asserts (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_freq_err_code(i_freq_err_code),
    .o_lock_lost_pin_n(o_lock_lost_pin_n), .o_irq_pin_n(o_irq_pin_n));

// file: dv/llsm_monitor_bench.sv
// Self-checking bench for the lock-lost status monitor.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ps
module llsm_monitor_bench
    import llsm_pkg::*;
;
    logic        i_clk;
    logic        i_reset_n;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic [3:0]  code;
    logic [5:0]  cause;
    logic        loop_tune;
    logic        lock_pin_n;
    logic        irq_n;
    int          errors;
    int          samples_checked;
    int          dev_bits[4] = '{0, 2, 3, 5};

    llsm_monitor dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
        .o_reg_rvalid(reg_rvalid), .i_freq_err_code(code), .i_device_tuning(cause[0]),
        .i_crystal_signal_missing(cause[2]), .i_crystal_unlocked(cause[3]),
        .i_bus_timeout(cause[5]), .i_loop_tuning(loop_tune),
        .o_lock_lost_pin_n(lock_pin_n), .o_irq_pin_n(irq_n));

    // 125 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic end_of_test;
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic pc(input logic got, input logic exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge i_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read one byte and compare it, with its valid pulse
    task automatic rc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge i_clk);
        reg_rd <= 1'b0;
        #1;
        pc(reg_rvalid, 1'b1);
        chk(reg_rdata, exp);
    endtask

    // Apply an error code, wait, check the lock-lost pin
    task automatic lk(input logic [3:0] c, input int n, input logic exp);
        @(posedge i_clk);
        code <= c;
        wt(n);
        pc(lock_pin_n, exp);
    endtask

    // Watchdog, about 20000 cycles
    initial begin
        #160000;
        errors++;
        end_of_test;
    end

    initial begin
        {i_reset_n, reg_wr, reg_rd, loop_tune} = 4'h0;
        {reg_addr, reg_wdata, code, cause} = 34'h0;
        errors = 0;
        samples_checked = 0;
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rc(LLSM_OFS_LOCK_MASK, 8'h00);
        rc(LLSM_OFS_ASSERT_LIM, 8'h20);
        rc(LLSM_OFS_TIMER_ON, 8'h00);
        wr(16'h0000, 8'hff);
        rc(16'h0000, 8'h00);
        rc(LLSM_OFS_LOCK_STICKY, 8'h02);
        pc(irq_n, 1'b0);
        // Clear refused while lost, accepted once locked
        lk(4'ha, 4, 1'b0);
        rc(LLSM_OFS_LOCK_LIVE, 8'h02);
        wr(LLSM_OFS_LOCK_STICKY, 8'h00);
        rc(LLSM_OFS_LOCK_STICKY, 8'h02);
        lk(4'h0, 4, 1'b1);
        rc(LLSM_OFS_LOCK_LIVE, 8'h00);
        wr(LLSM_OFS_LOCK_STICKY, 8'h00);
        rc(LLSM_OFS_LOCK_STICKY, 8'h00);
        pc(irq_n, 1'b1);
        // Masked lock loss keeps the interrupt quiet
        wr(LLSM_OFS_LOCK_MASK, 8'h02);
        lk(4'ha, 4, 1'b0);
        pc(irq_n, 1'b1);
        wr(LLSM_OFS_LOCK_MASK, 8'h00);
        wt(2);
        pc(irq_n, 1'b0);
        lk(4'h0, 4, 1'b1);
        wr(LLSM_OFS_LOCK_STICKY, 8'h00);
        wt(2);
        pc(irq_n, 1'b1);
        // Every set limit, then every clear limit below the top
        for (int k = 0; k < 9; k++) begin
            wr(LLSM_OFS_ASSERT_LIM, 8'(k << 4));
            lk(4'(k + 1), 6, 1'b1);
            lk(4'(k + 2), 4, 1'b0);
            lk(4'h0, 4, 1'b1);
        end
        for (int k = 0; k < 10; k++) begin
            wr(LLSM_OFS_REGAIN_LIM, 8'(k << 4));
            lk(4'ha, 4, 1'b0);
            lk(4'(k + 1), 6, 1'b0);
            lk(4'(k), 4, 1'b1);
        end
        wr(LLSM_OFS_ASSERT_LIM, 8'h20);
        wr(LLSM_OFS_REGAIN_LIM, 8'h00);
        // Clear timer of 20 cycles, restarted by a lost clear condition
        wr(LLSM_OFS_WAIT_B0, 8'h14);
        wr(LLSM_OFS_TIMER_ON, 8'h02);
        lk(4'ha, 4, 1'b0);
        lk(4'h0, 12, 1'b0);
        lk(4'h2, 3, 1'b0);
        lk(4'h0, 15, 1'b0);
        wt(10);
        pc(lock_pin_n, 1'b1);
        wr(LLSM_OFS_TIMER_ON, 8'h00);
        lk(4'ha, 4, 1'b0);
        lk(4'h0, 3, 1'b1);
        wr(LLSM_OFS_WAIT_B4, 8'hff);
        rc(LLSM_OFS_WAIT_B4, 8'h07);
        rc(LLSM_OFS_WAIT_B0, 8'h14);
        wr(LLSM_OFS_LOCK_STICKY, 8'h00);
        // Device status causes one at a time
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk);
            cause[dev_bits[i]] <= 1'b1;
            wt(3);
            rc(LLSM_OFS_DEV_LIVE, 8'(1 << dev_bits[i]));
            wr(LLSM_OFS_DEV_STICKY, 8'h00);
            rc(LLSM_OFS_DEV_STICKY, 8'(1 << dev_bits[i]));
            pc(irq_n, 1'b0);
            @(posedge i_clk);
            cause[dev_bits[i]] <= 1'b0;
            wt(3);
            wr(LLSM_OFS_DEV_STICKY, 8'h00);
            rc(LLSM_OFS_DEV_STICKY, 8'h00);
            pc(irq_n, 1'b1);
        end
        @(posedge i_clk);
        loop_tune <= 1'b1;
        wt(3);
        rc(LLSM_OFS_LOOP_LIVE, 8'h20);
        @(posedge i_clk);
        loop_tune <= 1'b0;
        wt(3);
        rc(LLSM_OFS_LOOP_STICKY, 8'h20);
        pc(irq_n, 1'b0);
        wr(LLSM_OFS_LOOP_MASK, 8'h20);
        wr(LLSM_OFS_DEV_MASK, 8'hff);
        rc(LLSM_OFS_DEV_MASK, 8'h2d);
        pc(irq_n, 1'b1);
        end_of_test;
    end
endmodule // llsm_monitor_bench
